// ### index_err_defs.svh
// constants for the index modification and operation error unit
`ifndef INDEX_ERR_DEFS_SVH
`define INDEX_ERR_DEFS_SVH

`define ADDR_IDX_BASE      12'h000
`define ADDR_ERR_CTRL      12'h040
`define ADDR_ERR_STATUS    12'h044
`define ADDR_ERR_CODE      12'h048
`define ADDR_ERR_ADDR_LO   12'h04C
`define ADDR_ERR_ADDR_HI   12'h050
`define ADDR_ERR_KIND      12'h054
`define NUM_OFFSET_REGS    14
`define DATA_WORD_LAST     32'sd32764
`define AREA_SMALL_LAST    32'sd511
`define BCD_MAX            32'sd9999
`define OP_ERROR_CODE      16'h0045
`define BLINK_HALF_CYCLES  25000000
`define CTRL_CONTINUE_BIT  0
`define CTRL_CLEAR_BIT     1
`define CTRL_RUN_BIT       2
`define CTRL_POWER_BIT     3

`endif

// ### index_err_pkg.sv
// types for the index modification and operation error unit
package index_err_pkg;
    typedef enum logic [2:0] {
        AREA_DATA_WORD    = 3'h0,
        AREA_INPUT_WORD   = 3'h1,
        AREA_OUTPUT_WORD  = 3'h2,
        AREA_RELAY_WORD   = 3'h3,
        AREA_TIMER_PRESET = 3'h4,
        AREA_TIMER_ELAPSE = 3'h5,
        AREA_CONSTANT     = 3'h6,
        AREA_OFFSET_REG   = 3'h7
    } area_t;

    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_RESOLVE  = 3'h1,
        OP_BCD_CHK  = 3'h2,
        OP_BIN2BCD  = 3'h3,
        OP_PARAM    = 3'h4,
        OP_BLOCK    = 3'h5,
        OP_DIVIDE   = 3'h6,
        OP_DIAG_SET = 3'h7
    } op_t;

    typedef enum logic [2:0] {
        RUN_EXEC  = 3'b001,
        RUN_HALT  = 3'b010,
        RUN_PROGRAMMING_MODE  = 3'b100
    } run_state_t;
endpackage

// ### index_err_unit.sv
// index modification and operation error detection unit
//
// Function
// - fourteen readable writable 16-bit offset registers
// - effective number is base plus offset
// - offsetting applies to all word areas
// - constants get offset added before use
// - offset register cannot be offset itself
// - 32-bit ops join first two offsets
// - error sets both flags, blinks indicator
// - error writes code into error code word
// - error captures faulting address in two words
// - out-of-range indexed number raises address error
// - data words above 32764 or negative fault
// - bad BCD nibble or conversion raises error
// - out-of-range control data raises parameter error
// - block span past area end raises error
// - divisor of zero raises error
// - halt on error unless continue selected
// - diag set instruction or tool clears error
// - run selector resumes at once after clear
// - programming mode power cycle clears error, code, address, kind and offsets
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`include "index_err_defs.svh"

module index_err_unit
    import index_err_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // sequencer request
    input  wire logic        op_valid,
    input  wire op_t         op_kind,
    input  wire area_t       op_area,
    input  wire logic        op_indexed,
    input  wire logic [3:0]  op_offset_sel,
    input  wire logic        op_wide,
    input  wire logic [15:0] op_base,
    input  wire logic [31:0] op_data,
    input  wire logic [15:0] op_limit,
    input  wire logic [31:0] op_pc,
    input  wire logic        off_wr,
    input  wire logic [3:0]  off_wr_sel,
    input  wire logic [15:0] off_wr_data,
    // sequencer answer
    output logic      [31:0] eff_value,
    output logic             eff_valid,
    output logic             op_error_flag_a,
    output logic             op_error_flag_b,
    output logic             exec_enable,
    output logic             error_led
);

    localparam int BLINK_HALF = `BLINK_HALF_CYCLES;

    typedef struct packed {
        logic [13:0][15:0] offs;
        logic              err;
        logic [15:0]       code;
        logic [31:0]       err_addr;
        logic [4:0]        kind;
        logic              cont;
        logic              run_sel;
        run_state_t        st;
        logic [24:0]       blink_cnt;
        logic              led;
        logic [31:0]       eff;
        logic              eff_v;
        logic [31:0]       rdata;
        logic              rdy;
        logic              serr;
        logic              exen;
    } state_t;

    state_t q, d;

    // sign-extended offset for the selected register, or registers 1 and 0 joined when wide selects 0
    function automatic logic signed [31:0] offset_of(
        input logic [13:0][15:0] offs,
        input logic [3:0]        sel,
        input logic              wide
    );
        logic signed [31:0] r;
        r = 32'sd0;
        if (sel < 4'd14) begin
            r = {{16{offs[sel][15]}}, offs[sel]};
        end
        if (wide && sel == 4'd0) begin
            r = {offs[1], offs[0]};
        end
        return r;
    endfunction

    // last valid number of each area
    function automatic logic signed [31:0] area_last(input area_t a);
        logic signed [31:0] r;
        r = `AREA_SMALL_LAST;
        if (a == AREA_DATA_WORD) begin
            r = `DATA_WORD_LAST;
        end
        return r;
    endfunction

    function automatic logic bad_bcd(input logic [31:0] v);
        logic b;
        b = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (v[i*4 +: 4] > 4'h9) begin
                b = 1'b1;
            end
        end
        return b;
    endfunction

    // offset registers fill the first words of the map
    function automatic logic is_offset_addr(input logic [11:0] a);
        return a[11:6] == 6'h00 && a[5:2] < 4'(`NUM_OFFSET_REGS);
    endfunction

    // number lies outside the usable part of its area
    function automatic logic outside_area(
        input logic signed [31:0] n,
        input area_t              a
    );
        return n < 32'sd0 || n > area_last(a);
    endfunction

    logic signed [31:0] eff_num;
    logic               fault;
    logic [4:0]         fault_kind;
    logic               apb_acc;
    logic [3:0]         widx;

    always_comb begin
        d          = q;
        eff_num    = 32'sd0;
        fault      = 1'b0;
        fault_kind = 5'h00;
        apb_acc    = psel && penable && !q.rdy;
        widx       = paddr[5:2];
        d.eff_v    = 1'b0;
        d.rdy      = 1'b0;
        d.serr     = 1'b0;

        // sequencer writes an offset register
        if (off_wr && off_wr_sel < 4'd14) begin
            d.offs[off_wr_sel] = off_wr_data;
        end

        if (op_valid && q.exen) begin
            eff_num = $signed({16'h0000, op_base});
            if (op_indexed) begin
                eff_num = eff_num
                    + offset_of(q.offs, op_offset_sel, op_wide);
            end
            case (op_kind)
                OP_RESOLVE: begin
                    if (op_indexed && op_area == AREA_OFFSET_REG) begin
                        fault      = 1'b1;
                        fault_kind = 5'h10;
                    end else if (op_area == AREA_CONSTANT) begin
                        d.eff   = eff_num;
                        d.eff_v = 1'b1;
                    end else if (outside_area(eff_num, op_area)) begin
                        fault      = 1'b1;
                        fault_kind = 5'h01;
                    end else begin
                        d.eff   = eff_num;
                        d.eff_v = 1'b1;
                    end
                end
                OP_BCD_CHK: begin
                    if (bad_bcd(op_data)) begin
                        fault      = 1'b1;
                        fault_kind = 5'h02;
                    end
                end
                OP_BIN2BCD: begin
                    if ($signed(op_data) < 0
                        || $signed(op_data) > `BCD_MAX) begin
                        fault      = 1'b1;
                        fault_kind = 5'h02;
                    end
                end
                OP_PARAM: begin
                    if (op_data > {16'h0000, op_limit}) begin
                        fault      = 1'b1;
                        fault_kind = 5'h04;
                    end
                end
                OP_BLOCK: begin
                    // start checked like any operand, then the span end
                    if (op_indexed && op_area == AREA_OFFSET_REG) begin
                        fault      = 1'b1;
                        fault_kind = 5'h10;
                    end else if (outside_area(eff_num, op_area)) begin
                        fault      = 1'b1;
                        fault_kind = 5'h01;
                    end else if (outside_area(eff_num + $signed(op_data)
                                              - 32'sd1, op_area)) begin
                        fault      = 1'b1;
                        fault_kind = 5'h08;
                    end
                end
                OP_DIVIDE: begin
                    if (op_data == 32'h0000_0000) begin
                        fault      = 1'b1;
                        fault_kind = 5'h08;
                    end
                end
                OP_DIAG_SET: begin
                    d.err = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // tool side registers over apb
        if (apb_acc && pwrite) begin
            if (paddr == `ADDR_ERR_CTRL) begin
                d.cont    = pwdata[`CTRL_CONTINUE_BIT];
                d.run_sel = pwdata[`CTRL_RUN_BIT];
                if (pwdata[`CTRL_CLEAR_BIT]) begin
                    d.err = 1'b0;
                end
                if (pwdata[`CTRL_POWER_BIT] && q.st == RUN_PROGRAMMING_MODE) begin
                    d.err  = 1'b0;
                    d.offs = '0;
                    d.code = 16'h0000;
                    d.err_addr = 32'h0000_0000;
                    d.kind = 5'h00;
                end
            end else if (is_offset_addr(paddr)) begin
                d.offs[widx] = pwdata[15:0];
            end else begin
                d.serr = 1'b1;
            end
        end else if (apb_acc) begin
            d.rdata = 32'h0000_0000;
            if (is_offset_addr(paddr)) begin
                d.rdata = {16'h0000, q.offs[widx]};
            end else begin
                case (paddr)
                    `ADDR_ERR_CTRL:
                        d.rdata = {28'h0, 1'b0, q.run_sel, 1'b0, q.cont};
                    `ADDR_ERR_STATUS:
                        d.rdata = {29'h0, q.st};
                    `ADDR_ERR_CODE:    d.rdata = {16'h0000, q.code};
                    `ADDR_ERR_ADDR_LO:
                        d.rdata = {16'h0000, q.err_addr[15:0]};
                    `ADDR_ERR_ADDR_HI:
                        d.rdata = {16'h0000, q.err_addr[31:16]};
                    `ADDR_ERR_KIND:    d.rdata = {27'h0, q.kind};
                    default:           d.serr  = 1'b1;
                endcase
            end
        end
        if (apb_acc) begin
            d.rdy = 1'b1;
        end

        // a new fault wins over any clear in the same cycle
        if (fault) begin
            d.err      = 1'b1;
            d.code     = `OP_ERROR_CODE;
            d.err_addr = op_pc;
            d.kind     = fault_kind;
        end

        // run control
        case (q.st)
            RUN_EXEC: begin
                if (!d.run_sel) begin
                    d.st = RUN_PROGRAMMING_MODE;
                end else if (fault && !q.cont) begin
                    d.st = RUN_HALT;
                end
            end
            RUN_HALT: begin
                if (!d.err && d.run_sel) begin
                    d.st = RUN_EXEC;
                end else if (!d.run_sel) begin
                    d.st = RUN_PROGRAMMING_MODE;
                end
            end
            RUN_PROGRAMMING_MODE: begin
                if (d.run_sel) begin
                    d.st = d.err && !q.cont ? RUN_HALT : RUN_EXEC;
                end
            end
            default: d.st = RUN_PROGRAMMING_MODE;
        endcase
        d.exen = (d.st == RUN_EXEC);

        // indicator blinks while an error stands
        if (d.err && !q.err) begin
            // lit at once, so a fresh fault shows without a wait
            d.blink_cnt = 25'h0;
            d.led       = 1'b1;
        end else if (d.err) begin
            if (q.blink_cnt == 25'(BLINK_HALF - 1)) begin
                d.blink_cnt = 25'h0;
                d.led       = ~q.led;
            end else begin
                d.blink_cnt = q.blink_cnt + 25'h1;
            end
        end else begin
            d.blink_cnt = 25'h0;
            d.led       = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            q.st      <= RUN_PROGRAMMING_MODE;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign prdata          = q.rdata;
    assign pready          = q.rdy;
    assign pslverr         = q.serr;
    assign eff_value       = q.eff;
    assign eff_valid       = q.eff_v;
    assign op_error_flag_a = q.err;
    assign op_error_flag_b = q.err;
    assign exec_enable     = q.exen;
    assign error_led       = q.led;

endmodule

// ### index_err_properties.sv
// assertions on the ports of the index and operation error unit
`timescale 1ns/100ps
module index_err_checker
    import index_err_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    // request
    input wire logic        op_valid,
    input wire op_t         op_kind,
    input wire area_t       op_area,
    input wire logic        op_indexed,
    input wire logic [15:0] op_base,
    input wire logic [31:0] op_data,
    input wire logic [15:0] op_limit,
    // answer
    input wire logic [31:0] eff_value,
    input wire logic        eff_valid,
    input wire logic        op_error_flag_a,
    input wire logic        op_error_flag_b,
    input wire logic        exec_enable,
    input wire logic        error_led
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // request actually taken this edge
    logic go;
    assign go = op_valid && exec_enable;
    flags_pair_a: assert property (
        op_error_flag_a == op_error_flag_b) else $error("flags differ");
    div_zero_a: assert property (
        go && op_kind == OP_DIVIDE && op_data == 32'h0
        |=> op_error_flag_a) else $error("zero divisor missed");
    bcd_range_a: assert property (
        go && op_kind == OP_BIN2BCD && (op_data[31] || op_data > 32'h270F)
        |=> op_error_flag_a) else $error("bcd range missed");
    param_range_a: assert property (
        go && op_kind == OP_PARAM && op_data > {16'h0000, op_limit}
        |=> op_error_flag_a) else $error("param range missed");
    const_value_a: assert property (
        go && op_kind == OP_RESOLVE && op_area == AREA_CONSTANT
        && !op_indexed |=> eff_valid
        && eff_value == {16'h0000, $past(op_base)})
        else $error("constant value wrong");
    offreg_bad_a: assert property (
        go && op_kind == OP_RESOLVE && op_area == AREA_OFFSET_REG
        && op_indexed |=> op_error_flag_a && !eff_valid)
        else $error("offset operand accepted");
    data_range_a: assert property (
        go && op_kind == OP_RESOLVE && op_area == AREA_DATA_WORD
        && !op_indexed && op_base > 16'h7FFC
        |=> op_error_flag_a && !eff_valid) else $error("range missed");
    halt_refuse_a: assert property (
        !exec_enable |=> !eff_valid) else $error("result while halted");
    diag_clear_a: assert property (
        go && op_kind == OP_DIAG_SET |=> !op_error_flag_a
        ##1 (!op_error_flag_a || $past(go)))
        else $error("diag set did not clear");
    led_idle_a: assert property (
        !op_error_flag_a |-> !error_led)
        else $error("led lit without error");
    led_fresh_a: assert property (
        $rose(op_error_flag_a) |-> error_led)
        else $error("led dark on error");
    apb_answer_a: assert property (
        psel && penable && !pready |=> pready) else $error("no pready");
    cover property (go && op_kind == OP_BLOCK);
    cover property (exec_enable && $rose(op_error_flag_a));
    cover property ($fell(exec_enable));
endmodule

bind index_err_unit index_err_checker index_err_checker_i (.*);

// ### seq_model.sv
// instruction sequencer model issuing requests to the unit
`timescale 1ns/100ps
module seq_model
    import index_err_pkg::*;
(
    // clock
    input wire logic  pclk,
    // request
    output logic        op_valid,
    output op_t         op_kind,
    output area_t       op_area,
    output logic        op_indexed,
    output logic [3:0]  op_offset_sel,
    output logic        op_wide,
    output logic [15:0] op_base,
    output logic [31:0] op_data,
    output logic [15:0] op_limit,
    output logic [31:0] op_pc,
    // offset register writes from instructions
    output logic        off_wr,
    output logic [3:0]  off_wr_sel,
    output logic [15:0] off_wr_data
);
    initial begin
        {op_valid, op_indexed, op_wide, off_wr} = 4'h0;
        op_kind = OP_NONE;
        op_area = AREA_DATA_WORD;
        {op_offset_sel, off_wr_sel} = 8'h00;
        {op_base, op_limit, off_wr_data} = 48'h0;
        {op_data, op_pc} = 64'h0;
    end
    // one request held over its taking edge; returns once result shows
    task automatic issue(input op_t k, input area_t a, input logic ix,
                         input logic [3:0] s, input logic w,
                         input logic [15:0] b, input logic [31:0] d,
                         input logic [15:0] l);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_kind <= k;
        op_area <= a;
        op_indexed <= ix;
        op_offset_sel <= s;
        op_wide <= w;
        op_base <= b;
        op_data <= d;
        op_limit <= l;
        op_pc <= op_pc + 32'h00010003;
        @(posedge pclk);
        op_valid <= 1'b0;
        // stale operands never look valid
        op_base <= ~b;
        op_data <= ~d;
        #1;
    endtask
    // instruction side write of one offset register
    task automatic load(input logic [3:0] s, input logic [15:0] v);
        @(posedge pclk);
        off_wr <= 1'b1;
        off_wr_sel <= s;
        off_wr_data <= v;
        @(posedge pclk);
        off_wr <= 1'b0;
        #1;
    endtask
endmodule

// ### index_modify_operation_error_unit_bench.sv
// self-checking bench for the index and operation error unit
`timescale 1ns/100ps
`include "index_err_defs.svh"
module index_modify_operation_error_unit_bench
    import index_err_pkg::*;
    ;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        op_valid, op_indexed, op_wide, off_wr, err;
    logic        eff_valid, op_error_flag_a, op_error_flag_b;
    logic        exec_enable, error_led;
    logic [3:0]  op_offset_sel, off_wr_sel;
    logic [11:0] paddr;
    logic [15:0] op_base, op_limit, off_wr_data;
    logic [31:0] pwdata, prdata, op_data, op_pc, eff_value, rd;
    op_t         op_kind;
    area_t       op_area;
    int          failures = 0;
    int          comparisons = 0;

    index_err_unit index_err_unit_i (.*);
    seq_model seq_model_i (.*);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic end_sim;
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_exec(input logic v);
        int n;
        n = 0;
        while (exec_enable !== v && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (exec_enable !== v) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic t_reset;
        apb(1'b0, `ADDR_ERR_STATUS, 32'h0);
        chk(rd, 32'h4);
        apb(1'b0, 12'h038, 32'h0);
        chk(err, 32'h1);
        chk(error_led, 32'h0);
    endtask
    task automatic t_offsets;
        apb(1'b1, 12'h034, 32'hFFFB);
        apb(1'b1, 12'h000, 32'hA);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h034, 32'h0);
        chk(rd, 32'hFFFB);
        seq_model_i.load(4'h2, 16'h1234);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h1234);
        apb(1'b1, `ADDR_ERR_CTRL, 32'h4);
        wait_exec(1'b1);
    endtask
    task automatic t_res(input area_t a, input logic ix, input logic [3:0] s,
                         input logic w, input logic [15:0] b,
                         input logic [31:0] exp);
        seq_model_i.issue(OP_RESOLVE, a, ix, s, w, b, 32'h0, 16'h0);
        chk({eff_valid, op_error_flag_a}, 32'h2);
        chk(eff_value, exp);
    endtask
    task automatic t_resolve;
        t_res(AREA_DATA_WORD, 1'b1, 4'h0, 1'b0, 16'h0, 32'hA);
        t_res(AREA_INPUT_WORD, 1'b1, 4'h0, 1'b0, 16'h3, 32'hD);
        t_res(AREA_CONSTANT, 1'b1, 4'hD, 1'b0, 16'h64, 32'h5F);
        t_res(AREA_CONSTANT, 1'b0, 4'h0, 1'b0, 16'h7, 32'h7);
        t_res(AREA_CONSTANT, 1'b1, 4'h0, 1'b1, 16'h2, 32'h1000C);
        t_res(AREA_DATA_WORD, 1'b0, 4'h0, 1'b0, 16'h7FFC, 32'h7FFC);
    endtask
    task automatic t_err(input op_t k, input area_t a, input logic ix,
                         input logic [15:0] b, input logic [31:0] d,
                         input logic [15:0] l, input logic [4:0] kind);
        seq_model_i.issue(k, a, ix, 4'hD, 1'b0, b, d, l);
        chk({op_error_flag_a, op_error_flag_b, exec_enable},
            {kind != 0, kind != 0, 1'b1});
        if (kind != 5'h0) begin
            apb(1'b0, `ADDR_ERR_KIND, 32'h0);
            chk(rd, {27'h0, kind});
            seq_model_i.issue(OP_DIAG_SET, a, 1'b0, 4'h0, 1'b0, 16'h0,
                              32'h0, 16'h0);
            chk(op_error_flag_a, 32'h0);
        end
    endtask
    task automatic t_kinds;
        apb(1'b1, `ADDR_ERR_CTRL, 32'h5);
        t_err(OP_RESOLVE, AREA_DATA_WORD, 0, 16'h7FFD, 0, 0, 5'h1);
        t_err(OP_RESOLVE, AREA_DATA_WORD, 1, 16'h0, 0, 0, 5'h1);
        t_err(OP_RESOLVE, AREA_INPUT_WORD, 0, 16'h200, 0, 0, 5'h1);
        t_err(OP_RESOLVE, AREA_OFFSET_REG, 1, 16'h0, 0, 0, 5'h10);
        t_err(OP_BCD_CHK, AREA_DATA_WORD, 0, 0, 32'h12A4, 0, 5'h2);
        t_err(OP_BCD_CHK, AREA_DATA_WORD, 0, 0, 32'h1299, 0, 5'h0);
        t_err(OP_BIN2BCD, AREA_DATA_WORD, 0, 0, 32'h2710, 0, 5'h2);
        t_err(OP_BIN2BCD, AREA_DATA_WORD, 0, 0, 32'h270F, 0, 5'h0);
        t_err(OP_BIN2BCD, AREA_DATA_WORD, 0, 0, '1, 0, 5'h2);
        t_err(OP_PARAM, AREA_DATA_WORD, 0, 0, 32'h6, 16'h5, 5'h4);
        t_err(OP_PARAM, AREA_DATA_WORD, 0, 0, 32'h5, 16'h5, 5'h0);
        t_err(OP_BLOCK, AREA_DATA_WORD, 0, 16'h7FF8, 32'h6, 0, 5'h8);
        t_err(OP_BLOCK, AREA_DATA_WORD, 0, 16'h7FF8, 32'h5, 0, 5'h0);
        t_err(OP_DIVIDE, AREA_DATA_WORD, 0, 0, 32'h0, 0, 5'h8);
        t_err(OP_DIVIDE, AREA_DATA_WORD, 0, 0, 32'h3, 0, 5'h0);
    endtask
    task automatic t_halt;
        apb(1'b1, `ADDR_ERR_CTRL, 32'h4);
        seq_model_i.issue(OP_RESOLVE, AREA_DATA_WORD, 1'b1, 4'hD, 1'b0,
                          16'h0, 32'h0, 16'h0);
        chk({op_error_flag_a, op_error_flag_b}, 32'h3);
        chk(error_led, 32'h1);
        wait_exec(1'b0);
        apb(1'b0, `ADDR_ERR_CODE, 32'h0);
        chk(rd, `OP_ERROR_CODE);
        apb(1'b0, `ADDR_ERR_ADDR_LO, 32'h0);
        chk(rd, seq_model_i.op_pc[15:0]);
        apb(1'b0, `ADDR_ERR_ADDR_HI, 32'h0);
        chk(rd, seq_model_i.op_pc[31:16]);
        apb(1'b1, `ADDR_ERR_CTRL, 32'h6);
        wait_exec(1'b1);
        chk(op_error_flag_a, 32'h0);
    endtask
    task automatic t_power;
        seq_model_i.issue(OP_DIVIDE, AREA_DATA_WORD, 1'b0, 4'h0, 1'b0,
                          16'h0, 32'h0, 16'h0);
        wait_exec(1'b0);
        apb(1'b1, `ADDR_ERR_CTRL, 32'h0);
        apb(1'b1, `ADDR_ERR_CTRL, 32'h8);
        apb(1'b0, `ADDR_ERR_STATUS, 32'h0);
        chk(rd, 32'h4);
        chk(op_error_flag_a, 32'h0);
        apb(1'b0, 12'h034, 32'h0);
        chk(rd, 32'h0);
    endtask
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_offsets();
        t_resolve();
        t_kinds();
        t_halt();
        t_power();
        end_sim();
    end
endmodule
